// ==== mcmr_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - bit 7 holds uart receiver, transmitter reset
// - line connect high passes serial pins through
// - line connect low: output high, input detached
// - bit 5 reads live receive line level
// - bit 4 flags new divisor latch write
// - bit 3 flags line control written
// - bit 2 flags transmit shadow holds character
// - bit 1 flags receive buffer was read
// - bit 0 flags modem control written
// - switch port bits 6..0 show switches
// - general bit 7 serial; reset/zero parallel
// - general bit 6 drives off hook output
// - general bit 3 drives auto answer low
// - general bit 2 drives speed pin low
// - indicators act only in serial configuration
// - general bit 1 selects register page
// - general bit 0 reads inverted access pin
module mcmr_regs (
  input  wire logic                   mclk,        // 200 MHz clock
  input  wire logic                   arst_n,      // async reset, active low
  input  wire mcmr_pkg::mcmr_bus_req_t bus,        // register port request
  output logic [7:0]                  rdata,       // read data, cycle after rd
  input  wire mcmr_pkg::mcmr_uart_evt_t uart_evt,  // uart event pulses
  input  wire logic                   uart_rx_line,// uart receive data level
  input  wire logic                   uart_tx_out, // serial data from uart
  input  wire logic                   serial_input_pin, // external serial in
  input  wire logic [6:0]             switch_inputs,    // external switches
  input  wire logic                   timer_tick,       // timer flip-flop toggle
  input  wire logic                   ext_access_n,     // active-low access pin
  output mcmr_pkg::mcmr_pins_t        pins              // device outputs
);
  import mcmr_pkg::*;

  mcmr_state_t st_reg;
  mcmr_state_t st_next;
  logic        wr_um;
  logic        wr_tf;
  logic        wr_gc;

  //////////////////////////////////////////////////////////////////////////////
  assign wr_um = bus.wr && (bus.addr == MCMR_OFF_UART_MONITOR);
  assign wr_tf = bus.wr && (bus.addr == MCMR_OFF_COUNTER_FLAG);
  assign wr_gc = bus.wr && (bus.addr == MCMR_OFF_GENERAL_CONTROL);

  always_comb begin
    st_next = st_reg;
    // software owns the two control bits; flags are hardware-driven
    if (wr_um) begin
      st_next.um[MCMR_UM_XCVR_RESET]   = bus.wdata[MCMR_UM_XCVR_RESET];
      st_next.um[MCMR_UM_LINE_CONNECT] = bus.wdata[MCMR_UM_LINE_CONNECT];
    end
    // flags follow uart events; a set in the same cycle as a clear wins
    if (uart_evt.div_written) st_next.um[MCMR_UM_DIV_WR] = 1'b1;
    else if (wr_um && bus.wdata[MCMR_UM_DIV_WR]) st_next.um[MCMR_UM_DIV_WR] = 1'b0;
    if (uart_evt.lcr_written) st_next.um[MCMR_UM_LCR_WR] = 1'b1;
    else if (wr_um && bus.wdata[MCMR_UM_LCR_WR]) st_next.um[MCMR_UM_LCR_WR] = 1'b0;
    if (uart_evt.tx_loaded) st_next.um[MCMR_UM_TX_FULL] = 1'b1;
    else if (uart_evt.tx_taken) st_next.um[MCMR_UM_TX_FULL] = 1'b0;
    if (uart_evt.rx_read) st_next.um[MCMR_UM_RX_READ] = 1'b1;
    else if (uart_evt.rx_new) st_next.um[MCMR_UM_RX_READ] = 1'b0;
    if (uart_evt.mcr_written) st_next.um[MCMR_UM_MCR_WR] = 1'b1;
    else if (wr_um && bus.wdata[MCMR_UM_MCR_WR]) st_next.um[MCMR_UM_MCR_WR] = 1'b0;
    st_next.um[MCMR_UM_RX_LEVEL] = 1'b0; // live value is muxed on read
    // timer flip-flop toggles on tick; software may also load it
    if (timer_tick) st_next.tff = ~st_reg.tff;
    else if (wr_tf) st_next.tff = bus.wdata[0];
    if (wr_gc) begin
      st_next.gc = bus.wdata;
      st_next.gc[MCMR_GC_EXT_ACC] = 1'b0; // status only, never stored
    end
    st_next.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        MCMR_OFF_UART_MONITOR: begin
          st_next.rdata = st_reg.um;
          st_next.rdata[MCMR_UM_RX_LEVEL] = uart_rx_line;
        end
        MCMR_OFF_SWITCH_PORT: st_next.rdata = {1'b0, switch_inputs};
        MCMR_OFF_COUNTER_FLAG: st_next.rdata = {7'h00, st_reg.tff};
        MCMR_OFF_GENERAL_CONTROL: begin
          st_next.rdata = st_reg.gc;
          st_next.rdata[MCMR_GC_EXT_ACC] = ~ext_access_n;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.um    <= MCMR_UM_RESET;
      st_reg.gc    <= MCMR_GC_RESET;
      st_reg.tff   <= MCMR_TFF_RESET;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic serial_on;
  logic connect;
  assign serial_on = st_reg.gc[MCMR_GC_SERIAL];
  assign connect   = st_reg.um[MCMR_UM_LINE_CONNECT];
  assign rdata     = st_reg.rdata;

  always_comb begin
    pins.uart_reset  = st_reg.um[MCMR_UM_XCVR_RESET];
    // detached input idles high so the receiver sees a quiet line
    pins.uart_sin    = connect ? serial_input_pin : 1'b1;
    // echo works because serial_output_pin is forced high while detached and carries the uart break low while connected
    pins.serial_output_pin_pin    = connect ? uart_tx_out : 1'b1;
    pins.off_hook    = st_reg.gc[MCMR_GC_OFFHOOK];
    pins.aux_out     = st_reg.gc[MCMR_GC_AUX];
    pins.modem_ready = serial_on & st_reg.gc[MCMR_GC_MODEM_READY_BIT];
    pins.auto_answer_n = ~(serial_on & st_reg.gc[MCMR_GC_AA]);
    pins.speed_n     = ~(serial_on & st_reg.gc[MCMR_GC_SPEED]);
    pins.serial_cfg  = serial_on;
    pins.page_sel    = st_reg.gc[MCMR_GC_PAGE];
  end

endmodule : mcmr_regs

// ==== mcmr_pkg.sv ====
package mcmr_pkg;

  // register offsets (local index of this bank)
  localparam logic [1:0] MCMR_OFF_UART_MONITOR    = 2'h0;
  localparam logic [1:0] MCMR_OFF_SWITCH_PORT     = 2'h1;
  localparam logic [1:0] MCMR_OFF_COUNTER_FLAG    = 2'h2;
  localparam logic [1:0] MCMR_OFF_GENERAL_CONTROL = 2'h3;

  // uart monitor field positions
  localparam int MCMR_UM_XCVR_RESET   = 7;
  localparam int MCMR_UM_LINE_CONNECT = 6;
  localparam int MCMR_UM_RX_LEVEL     = 5;
  localparam int MCMR_UM_DIV_WR       = 4;
  localparam int MCMR_UM_LCR_WR       = 3;
  localparam int MCMR_UM_TX_FULL      = 2;
  localparam int MCMR_UM_RX_READ      = 1;
  localparam int MCMR_UM_MCR_WR       = 0;

  // general control field positions
  localparam int MCMR_GC_SERIAL  = 7;
  localparam int MCMR_GC_OFFHOOK = 6;
  localparam int MCMR_GC_AUX     = 5;
  localparam int MCMR_GC_MODEM_READY_BIT    = 4;
  localparam int MCMR_GC_AA      = 3;
  localparam int MCMR_GC_SPEED   = 2;
  localparam int MCMR_GC_PAGE    = 1;
  localparam int MCMR_GC_EXT_ACC = 0;

  localparam int MCMR_SWITCH_COUNT = 7;

  // reset values
  localparam logic [7:0] MCMR_UM_RESET = 8'h00;
  localparam logic [7:0] MCMR_GC_RESET = 8'h00;
  localparam logic       MCMR_TFF_RESET = 1'b0;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mcmr_bus_req_t;

  // events reported by the attached uart core
  typedef struct packed {
    logic div_written;
    logic lcr_written;
    logic tx_loaded;
    logic tx_taken;
    logic rx_read;
    logic rx_new;
    logic mcr_written;
  } mcmr_uart_evt_t;

  typedef struct packed {
    logic uart_reset;
    logic uart_sin;
    logic serial_output_pin_pin;
    logic off_hook;
    logic aux_out;
    logic modem_ready;
    logic auto_answer_n;
    logic speed_n;
    logic serial_cfg;
    logic page_sel;
  } mcmr_pins_t;

  typedef struct packed {
    logic [7:0] um;
    logic [7:0] gc;
    logic       tff;
    logic [7:0] rdata;
  } mcmr_state_t;

endpackage : mcmr_pkg

// ==== mcmr_chk.sv ====
`timescale 1ns/1ps
module mcmr_chk (
  input wire logic                    mclk,             // clock
  input wire logic                    arst_n,           // reset
  input wire mcmr_pkg::mcmr_bus_req_t bus,              // request
  input wire logic [7:0]              rdata,            // read data
  input wire logic                    uart_rx_line,     // rx level
  input wire logic                    uart_tx_out,      // uart out
  input wire logic                    serial_input_pin, // serial in
  input wire logic [6:0]              switch_inputs,    // switches
  input wire logic                    ext_access_n,     // access pin
  input wire mcmr_pkg::mcmr_pins_t    pins              // outputs
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // a low output can only come from the uart when connected
  a_serial_output_pin_forced_high: assert property (!pins.serial_output_pin_pin |-> !uart_tx_out) else $error("serial_output_pin");
  a_sin_detached: assert property (!pins.uart_sin |-> !serial_input_pin) else $error("sin");
  a_aa_gated: assert property (!pins.auto_answer_n |-> pins.serial_cfg) else $error("aa");
  a_speed_gated: assert property (!pins.speed_n |-> pins.serial_cfg) else $error("hs");
  a_serial_write: assert property (bus.wr && bus.addr == 2'h3 |=>
    pins.serial_cfg == $past(bus.wdata[7])) else $error("serial cfg");
  a_xcvr_reset_write: assert property (bus.wr && bus.addr == 2'h0 |=>
    pins.uart_reset == $past(bus.wdata[7])) else $error("uart reset");
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00) else $error("rdata idle");
  a_switch_read: assert property (bus.rd && bus.addr == 2'h1 |=>
    rdata == {1'b0, $past(switch_inputs)}) else $error("switch read");
  a_ext_access_read: assert property (bus.rd && bus.addr == 2'h3 |=>
    rdata[0] == !$past(ext_access_n)) else $error("ext access");
  a_rx_level_read: assert property (bus.rd && bus.addr == 2'h0 |=>
    rdata[5] == $past(uart_rx_line)) else $error("rx level");
  c_indicator: cover property (!pins.auto_answer_n);
  c_mon_read: cover property (bus.rd && bus.addr == 2'h0);
  c_xcvr_reset: cover property (pins.uart_reset);
endmodule : mcmr_chk
bind mcmr_regs mcmr_chk mcmr_chk_i (.mclk, .arst_n, .bus, .rdata, .uart_rx_line, .uart_tx_out,
  .serial_input_pin, .switch_inputs, .ext_access_n, .pins);

// ==== mcmr_tb.sv ====
`timescale 1ns/1ps
module tb_top;
  import mcmr_pkg::*;
  logic           mclk = 1'b0;
  logic           arst_n = 1'b0;
  mcmr_bus_req_t  bus = '0;
  mcmr_uart_evt_t uart_evt = '0;
  logic           uart_rx_line = 1'b0, uart_tx_out = 1'b1, serial_input_pin = 1'b1;
  logic           timer_tick = 1'b0, ext_access_n = 1'b1;
  logic [6:0]     switch_inputs = 7'h55;
  logic [7:0]     rdata;
  mcmr_pins_t     pins;
  int             err_total = 0, n_tests = 0;
  mcmr_regs mcmr_regs_i (.mclk, .arst_n, .bus, .rdata, .uart_evt, .uart_rx_line, .uart_tx_out,
    .serial_input_pin, .switch_inputs, .timer_tick, .ext_access_n, .pins);
  initial forever #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task chk(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // pin order: reset sin serial_output_pin hook aux rdy aa_n hs_n serial page
  task chkp(string n, logic [9:0] e);
    chk(n, e[9:2], pins[9:2]);
    chk(n, {6'h0, e[1:0]}, {6'h0, pins[1:0]});
  endtask : chkp
  task wr(logic [1:0] a, logic [7:0] d);
    @(posedge mclk) bus <= {a, d, 2'b10};
    @(posedge mclk) bus <= '0;
    #1;
  endtask : wr
  task rd(logic [1:0] a, logic [7:0] e, string n);
    @(posedge mclk) bus <= {a, 8'h00, 2'b01};
    @(posedge mclk) bus <= '0;
    #1 chk(n, e, rdata);
  endtask : rd
  task ev(mcmr_uart_evt_t e);
    @(posedge mclk) uart_evt <= e;
    @(posedge mclk) uart_evt <= '0;
  endtask : ev
  ////////////////////////////////////////////////////////////////
  task t_mon;
    chkp("pins_rst", 10'b0110001100);
    rd(2'h0, 8'h00, "um_rst");
    wr(2'h0, 8'h80);
    chkp("xcvr_rst", 10'b1110001100);
    wr(2'h0, 8'h40);
    @(posedge mclk) {uart_tx_out, serial_input_pin} <= 2'b00;
    #1 chkp("connect", 10'b0000001100);
    wr(2'h0, 8'h00);
    chkp("isolate", 10'b0110001100);
    @(posedge mclk) uart_rx_line <= 1'b1;
    rd(2'h0, 8'h20, "rx_level");
    @(posedge mclk) uart_rx_line <= 1'b0;
  endtask : t_mon
  task t_flags;
    ev(7'b1110101);
    rd(2'h0, 8'h1f, "flags_set");
    wr(2'h0, 8'h19);
    rd(2'h0, 8'h06, "flags_w1c");
    ev(7'b0001010);
    rd(2'h0, 8'h00, "flags_clr");
    // event and clear in one cycle: the hardware set must win
    @(posedge mclk) begin
      uart_evt <= 7'b1000000;
      bus      <= {2'h0, 8'h10, 2'b10};
    end
    @(posedge mclk) begin
      uart_evt <= '0;
      bus      <= '0;
    end
    rd(2'h0, 8'h10, "set_wins");
    wr(2'h0, 8'h10);
    rd(2'h0, 8'h00, "set_clr");
  endtask : t_flags
  // echo: uart held in break, software writes line connect as inverse of rx level
  task t_echo;
    @(posedge mclk) {uart_tx_out, uart_rx_line} <= 2'b01;
    rd(2'h0, 8'h20, "echo_lvl1");
    wr(2'h0, 8'h00);
    chk("echo_1", 8'h01, {7'h00, pins.serial_output_pin_pin});
    @(posedge mclk) uart_rx_line <= 1'b0;
    rd(2'h0, 8'h00, "echo_lvl0");
    wr(2'h0, 8'h40);
    chk("echo_0", 8'h00, {7'h00, pins.serial_output_pin_pin});
  endtask : t_echo
  task t_gc;
    wr(2'h3, 8'h5c);
    chkp("parallel", 10'b0111001100);
    wr(2'h3, 8'hdc);
    chkp("serial", 10'b0111010010);
    wr(2'h3, 8'h22);
    chkp("page", 10'b0110101101);
    @(posedge mclk) ext_access_n <= 1'b0;
    rd(2'h3, 8'h23, "gc_read");
  endtask : t_gc
  task t_misc;
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h55, "switch");
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h01, "cnt_wr");
    @(posedge mclk) timer_tick <= 1'b1;
    @(posedge mclk) timer_tick <= 1'b0;
    rd(2'h2, 8'h00, "cnt_tick");
  endtask : t_misc
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_mon;
    t_flags;
    t_gc;
    t_misc;
    t_echo;
    print_verdict;
  end
endmodule : tb_top
